/* File: src/msend_top.sv */
// What this block does
// - Flag clear: raise vector when sequence ends
// - Flag set: no vector on sequence end
// - Processing mode comes from mode byte
// - Channel found through channel pointer byte
// - Each source owns one RAM control word, except serial2 receive and sync2, which share one
// - Stop condition word at 0FE30/0FE31
// - Serial2 transmit word at 0FE2E/0FE2F
// - Serial2 receive and sync2 share 0FE2C/0FE2D
// - Sync serial word at 0FE28/0FE29
// - End-vector flag is mode bit 7
// - Complete when countdown reaches zero
`include "msend_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module msend_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Internal RAM port for the control words
  input  wire logic [15:0] ram_addr,
  input  wire logic        ram_wr,
  input  wire logic        ram_rd,
  input  wire logic [7:0]  ram_wdata,
  output logic      [7:0]  ram_rdata,
  output logic             ram_hit,
  // Peripheral service requests
  input  wire logic        sync_serial_done_irq,
  input  wire logic        serial2_rx_done_irq,
  input  wire logic        sync_serial2_done_irq,
  input  wire logic        serial2_tx_done_irq,
  input  wire logic        stop_condition_irq,
  // Channel memory port
  output logic      [7:0]  chan_addr,
  output logic             chan_rd,
  output logic             chan_we,
  output logic      [15:0] transfer_countdown,
  input  wire logic [15:0] chan_rdata,
  // Transfer request to the data mover
  output logic             svc_strobe,
  output logic      [7:0]  svc_mode,
  output logic      [7:0]  svc_chan,
  // Vectored interrupt requests, one pulse per completed sequence whose mode bit 7 is clear
  output logic      [4:0]  vec_irq
);

  // Control bytes: even index is mode, odd index is channel pointer
  logic [7:0]               ctl [0:`MSEND_NUM_BYTES-1];
  logic [4:0]               pend;
  logic [2:0]               cur_src;
  logic [7:0]               cur_mode;
  logic [7:0]               cur_chp;
  msend_pkg::msend_state_t  state;
  logic [4:0]               req;
  logic [4:0]               take;
  logic                     any_pend;
  logic [2:0]               next_src;
  logic [3:0]               dec;
  logic [15:0]              next_count;
  logic                     upd_go;
  logic                     upd_end;

  // Byte address to control byte index; the FE2A/FE2B word is not ours
  function automatic logic [3:0] ctl_decode(input logic [15:0] a);
    case (a)
      `MSEND_SYNC_MODE_ADDR:    ctl_decode = {1'b1, 3'd0};
      `MSEND_SYNC_CHP_ADDR:     ctl_decode = {1'b1, 3'd1};
      `MSEND_SER2_RX_MODE_ADDR: ctl_decode = {1'b1, 3'd2};
      `MSEND_SER2_RX_CHP_ADDR:  ctl_decode = {1'b1, 3'd3};
      `MSEND_SER2_TX_MODE_ADDR: ctl_decode = {1'b1, 3'd4};
      `MSEND_SER2_TX_CHP_ADDR:  ctl_decode = {1'b1, 3'd5};
      `MSEND_STOP_MODE_ADDR:    ctl_decode = {1'b1, 3'd6};
      `MSEND_STOP_CHP_ADDR:     ctl_decode = {1'b1, 3'd7};
      default:                  ctl_decode = 4'h0;
    endcase
  endfunction : ctl_decode

  // Source to control word; serial2 receive and sync2 use one word
  function automatic logic [2:0] word_base(input logic [2:0] s);
    case (s)
      3'd0:    word_base = 3'd0;
      3'd1:    word_base = 3'd2;
      3'd2:    word_base = 3'd2;
      3'd3:    word_base = 3'd4;
      default: word_base = 3'd6;
    endcase
  endfunction : word_base

  assign req = {stop_condition_irq, serial2_tx_done_irq, sync_serial2_done_irq,
                serial2_rx_done_irq, sync_serial_done_irq};
  assign dec = ctl_decode(ram_addr);
  assign next_count = chan_rdata - `MSEND_COUNT_ONE;

  // Update cycle with a live count; a count already at zero means the sequence ended
  assign upd_go  = (state == msend_pkg::MSEND_UPDATE) && (chan_rdata != `MSEND_COUNT_ZERO);
  // Last transfer of the sequence with the end vector not suppressed
  assign upd_end = upd_go && (next_count == `MSEND_COUNT_ZERO) &&
                   !cur_mode[`MSEND_END_VEC_SUPPRESS_BIT];

  // Fixed priority: lowest source index is served first
  always_comb begin
    any_pend = 1'b0;
    next_src = 3'd0;
    for (int i = `MSEND_NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        any_pend = 1'b1;
        next_src = 3'(i);
      end
    end
  end

  // Pending is cleared when taken; a new request in that cycle wins
  always_comb begin
    take = 5'h00;
    if (state == msend_pkg::MSEND_IDLE && any_pend) begin
      take[next_src] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pend <= 5'h00;
    end else begin
      pend <= (pend & ~take) | req;
    end
  end

  // Software writes and reads the control words
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `MSEND_NUM_BYTES; i++) begin
        ctl[i] <= `MSEND_CTL_RESET;
      end
    end else if (ram_wr && dec[3]) begin
      ctl[dec[2:0]] <= ram_wdata;
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ram_rdata <= 8'h00;
      ram_hit   <= 1'b0;
    end else begin
      ram_hit   <= (ram_rd || ram_wr) && dec[3];
      ram_rdata <= (ram_rd && dec[3]) ? ctl[dec[2:0]] : 8'h00;
    end
  end

  // Service sequencer: fetch word, read countdown, write it back
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= msend_pkg::MSEND_IDLE;
      cur_src  <= 3'd0;
      cur_mode <= 8'h00;
      cur_chp  <= 8'h00;
    end else begin
      case (state)
        msend_pkg::MSEND_IDLE: begin
          if (any_pend) begin
            cur_src <= next_src;
            state   <= msend_pkg::MSEND_FETCH;
          end
        end
        msend_pkg::MSEND_FETCH: begin
          // Control word is taken as software left it
          cur_mode <= ctl[word_base(cur_src)];
          cur_chp  <= ctl[word_base(cur_src) + 3'd1];
          state    <= msend_pkg::MSEND_READ;
        end
        msend_pkg::MSEND_READ: begin
          // One cycle of channel memory latency
          state <= msend_pkg::MSEND_UPDATE;
        end
        msend_pkg::MSEND_UPDATE: begin
          state <= msend_pkg::MSEND_IDLE;
        end
        default: begin
          state <= msend_pkg::MSEND_IDLE;
        end
      endcase
    end
  end

  // Channel memory port; the pointer goes out with the read pulse
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_addr          <= 8'h00;
      chan_rd            <= 1'b0;
      chan_we            <= 1'b0;
      transfer_countdown <= `MSEND_COUNT_ZERO;
    end else begin
      chan_rd <= (state == msend_pkg::MSEND_FETCH);
      chan_we <= upd_go;
      if (state == msend_pkg::MSEND_FETCH) begin
        chan_addr <= ctl[word_base(cur_src) + 3'd1];
      end
      if (upd_go) begin
        transfer_countdown <= next_count;
      end
    end
  end

  // Hand one transfer on; mode and channel hold so the mover may take them late
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      svc_strobe <= 1'b0;
      svc_mode   <= 8'h00;
      svc_chan   <= 8'h00;
    end else begin
      svc_strobe <= upd_go;
      if (upd_go) begin
        svc_mode <= cur_mode;
        svc_chan <= cur_chp;
      end
    end
  end

  // One vector pulse per ended sequence, only while the flag is clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      vec_irq <= 5'h00;
    end else begin
      vec_irq <= 5'h00;
      if (upd_end) begin
        vec_irq[cur_src] <= 1'b1;
      end
    end
  end

endmodule : msend_top
`default_nettype wire

/* File: src/msend_cfg.svh */
`ifndef MSEND_CFG_SVH
`define MSEND_CFG_SVH

// Control word byte addresses in internal RAM
`define MSEND_SYNC_MODE_ADDR      16'hfe28
`define MSEND_SYNC_CHP_ADDR       16'hfe29
`define MSEND_SER2_RX_MODE_ADDR   16'hfe2c
`define MSEND_SER2_RX_CHP_ADDR    16'hfe2d
`define MSEND_SER2_TX_MODE_ADDR   16'hfe2e
`define MSEND_SER2_TX_CHP_ADDR    16'hfe2f
`define MSEND_STOP_MODE_ADDR      16'hfe30
`define MSEND_STOP_CHP_ADDR       16'hfe31

// Field positions and sizes
`define MSEND_END_VEC_SUPPRESS_BIT 7
`define MSEND_NUM_SRC              5
`define MSEND_NUM_BYTES            8
`define MSEND_CTL_RESET            8'h00
`define MSEND_COUNT_ZERO           16'h0000
`define MSEND_COUNT_ONE            16'h0001

`endif

/* File: src/msend_pkg.sv */
`default_nettype none
package msend_pkg;
  // Service sequencer states
  typedef enum logic [2:0] {
    MSEND_IDLE,
    MSEND_FETCH,
    MSEND_READ,
    MSEND_UPDATE
  } msend_state_t;
endpackage : msend_pkg
`default_nettype wire

/* File: sim/msend_top_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module msend_top_monitor (
  // Watched top ports
  input wire logic clk_sys, sys_rst, ram_rd, ram_hit, chan_rd, chan_we, svc_strobe,
  input wire logic [15:0] ram_addr, transfer_countdown, chan_rdata,
  input wire logic [7:0] svc_mode,
  input wire logic [4:0] vec_irq
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_vec_end: assert property (|vec_irq |-> chan_we && ~|transfer_countdown)
    else $error("early vector");
  chk_vec_flag: assert property (|vec_irq |-> svc_strobe && !svc_mode[7])
    else $error("vector not suppressed");
  chk_vec_raise: assert property (svc_strobe && ~|transfer_countdown && !svc_mode[7]
    |-> $onehot(vec_irq)) else $error("vector missing");
  chk_vec_one: assert property ($onehot0(vec_irq)) else $error("two vectors");
  chk_strobe_path: assert property (svc_strobe |-> chan_we && $past(chan_rd, 2))
    else $error("no channel read");
  chk_count_dec: assert property (chan_we |->
    transfer_countdown + 16'h0001 == $past(chan_rdata)) else $error("bad count");
  chk_word_hit: assert property (ram_rd && ram_addr == 16'hfe31 |=> ram_hit)
    else $error("word missed");
  chk_gap_dead: assert property (ram_rd && ram_addr == 16'hfe2a |=> !ram_hit)
    else $error("gap answered");
  // Main paths seen once each
  cover property (|vec_irq);
  cover property (svc_strobe && svc_mode[7]);
  cover property (ram_hit);
endmodule : msend_top_monitor
bind msend_top msend_top_monitor u_mon (.clk_sys, .sys_rst, .ram_rd, .ram_hit, .chan_rd,
  .chan_we, .svc_strobe, .ram_addr, .transfer_countdown, .chan_rdata, .svc_mode, .vec_irq);
`default_nettype wire

/* File: sim/msend_chan_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module msend_chan_mem (
  // Channel memory port
  input wire logic clk_sys, chan_rd, chan_we,
  input wire logic [7:0] chan_addr,
  input wire logic [15:0] transfer_countdown,
  output logic [15:0] chan_rdata
);
  logic [15:0] words [256];
  // Answer on the edge after the pulse, so it stands when the sequencer samples;
  // otherwise show a nonzero filler so a mistimed sample would spend a transfer
  always @(posedge clk_sys) begin
    chan_rdata <= chan_rd ? words[chan_addr] : 16'hffff;
    if (chan_we) words[chan_addr] <= transfer_countdown;
  end
endmodule : msend_chan_mem
`default_nettype wire

/* File: sim/test_msend_top.sv */
`timescale 1ns/1ns
`default_nettype none
module test_msend_top;
  // Stimulus, responses and tallies
  logic clk_sys, sys_rst, ram_wr, ram_rd, ram_hit, chan_rd, chan_we, svc_strobe;
  logic [15:0] ram_addr, transfer_countdown, chan_rdata;
  logic [7:0] ram_wdata, ram_rdata, chan_addr, svc_mode, svc_chan;
  logic [4:0] irq, vec_irq, seen;
  int fails = 0, samples_checked = 0, n;
  msend_top DUT (.clk_sys, .sys_rst, .ram_addr, .ram_wr, .ram_rd, .ram_wdata, .ram_rdata,
    .ram_hit, .sync_serial_done_irq(irq[0]), .serial2_rx_done_irq(irq[1]),
    .sync_serial2_done_irq(irq[2]), .serial2_tx_done_irq(irq[3]), .stop_condition_irq(irq[4]),
    .chan_addr, .chan_rd, .chan_we, .transfer_countdown, .chan_rdata, .svc_strobe, .svc_mode,
    .svc_chan, .vec_irq);
  msend_chan_mem u_far (.clk_sys, .chan_rd, .chan_we, .chan_addr, .transfer_countdown,
    .chan_rdata);
  task automatic check(input logic [15:0] got, want);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Request held one edge; the answer stands in the cycle after
  task automatic ram_acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    {ram_addr, ram_wr, ram_rd, ram_wdata} <= {a, w, !w, d};
    @(posedge clk_sys);
    {ram_wr, ram_rd} <= 2'b00;
    #1;
  endtask : ram_acc
  // Reset value, then a write into the unmapped gap must leave nothing behind
  task automatic t_gap();
    ram_acc(16'hfe31, 1'b0, 8'h00);
    check({ram_hit, ram_rdata}, 9'h100);
    ram_acc(16'hfe2a, 1'b1, 8'h5a);
    ram_acc(16'hfe2a, 1'b0, 8'h00);
    check({ram_hit, ram_rdata}, 9'h000);
    $display("gap test done");
  endtask : t_gap
  // Fill the word, preset the count, pulse the source, then judge the outcome
  task automatic t_svc(input int s, input logic [15:0] a, input logic [7:0] mode, ptr,
    input logic [15:0] cnt);
    ram_acc(a, 1'b1, mode);
    ram_acc(a + 16'h0001, 1'b1, ptr);
    ram_acc(a, 1'b0, 8'h00);
    check({ram_hit, ram_rdata}, {1'b1, mode});
    @(posedge clk_sys);
    u_far.words[ptr] <= cnt;
    irq[s] <= 1'b1;
    @(posedge clk_sys);
    irq <= 5'h00;
    n = 0;
    seen = 5'h00;
    repeat (10) begin
      @(posedge clk_sys);
      #1 seen |= vec_irq;
      n += svc_strobe === 1'b1;
    end
    check(16'(n), 16'(cnt != 0));
    if (cnt != 0) check(svc_mode, mode);
    if (cnt != 0) check(svc_chan, ptr);
    check(u_far.words[ptr], cnt - 16'(cnt != 0));
    check(seen, (cnt == 1 && !mode[7]) ? 16'h0001 << s : 16'h0000);
    $display("service test %0d done", s);
  endtask : t_svc
  // Free running clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    {sys_rst, ram_wr, ram_rd, ram_addr, ram_wdata, irq} = {3'b100, 16'h0000, 8'h00, 5'h00};
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_gap();
    t_svc(0, 16'hfe28, 8'h00, 8'h10, 16'h0001);
    t_svc(1, 16'hfe2c, 8'h01, 8'h20, 16'h0003);
    t_svc(2, 16'hfe2c, 8'h00, 8'h30, 16'h0000);
    t_svc(3, 16'hfe2e, 8'h80, 8'h40, 16'h0001);
    t_svc(4, 16'hfe30, 8'h00, 8'h50, 16'h0001);
    print_verdict();
  end
endmodule : test_msend_top
`default_nettype wire
